// file: rtl/eecfg_pkg.sv
package eecfg_pkg;
    // Core clock and self-timed write cycle
    localparam int MCLK_PERIOD_NS = 4;
    localparam int WR_TIME_US = 1000;
    localparam int WR_CYCLES = (WR_TIME_US * 1000 + MCLK_PERIOD_NS - 1) / MCLK_PERIOD_NS;
    // Device address byte
    localparam logic [3:0] DEV_TYPE = 4'hb;
    // Positions of A15, A11 and A10 inside word address byte 0
    localparam int WA_A15 = 7;
    localparam int WA_A11 = 3;
    localparam int WA_A10 = 2;
    // Confirmation byte values
    localparam logic [7:0] CONF_LOCK = 8'h99;
    localparam logic [7:0] CONF_OPEN = 8'h66;
    // Fields of the upper register byte
    localparam int HI_ECS = 7;
    localparam int HI_MODE = 1;
    localparam int HI_LOCK = 0;
    // Zone geometry of the array
    localparam int ZONE_BYTES = 8192;
    localparam int ZONE_LSB = $clog2(ZONE_BYTES);
    // Reset values
    localparam logic [7:0] ZONE_RST = 8'h00;
    localparam logic MODE_RST = 1'h0;
    localparam logic LOCK_RST = 1'h0;
    // Widths of words crossing between domains
    localparam int REQ_W = 24;
    localparam int SNAP_W = 16;
    // Link bit counter and byte counter marks
    localparam logic [3:0] BIT_ACK = 4'h8;
    localparam logic [3:0] BIT_ACK_END = 4'h9;
    localparam logic [2:0] WCNT_FULL = 3'h3;
    localparam logic [2:0] WCNT_OVER = 3'h4;

    typedef enum logic [2:0]
    {
        ST_IDLE = 3'h0,
        ST_DEV = 3'h1,
        ST_AHI = 3'h3,
        ST_ALO = 3'h2,
        ST_WDAT = 3'h6,
        ST_RDAT = 3'h7
    } eecfg_lst_t;
endpackage

// file: rtl/eecfg_xfer_if.sv
`timescale 1ns/100ps
interface eecfg_xfer_if #(parameter int W = 8);
    logic s_valid;
    logic s_ready;
    logic [W-1:0] s_data;
    logic d_valid;
    logic [W-1:0] d_data;
    modport xfer (input s_valid, input s_data, output s_ready, output d_valid, output d_data);
    modport user (output s_valid, output s_data, input s_ready, input d_valid, input d_data);
endinterface

// file: rtl/eecfg_sync.sv
`timescale 1ns/100ps
module eecfg_sync #(parameter int W = 1)
(
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Level in and out
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);
    logic [W-1:0] meta;

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            meta <= '0;
            q <= '0;
        end
        else
        begin
            meta <= d;
            q <= meta;
        end
    end
endmodule

// file: rtl/eecfg_xfer.sv
`timescale 1ns/100ps
module eecfg_xfer
(
    // Clocks and reset
    input wire logic s_clk,
    input wire logic d_clk,
    input wire logic rst,
    // Word channel
    eecfg_xfer_if.xfer x
);
    localparam int W = $bits(x.s_data);
    logic req_tgl;
    logic seen_tgl;
    logic req_d;
    logic ack_s;
    logic [W-1:0] hold;

    eecfg_sync u_req (.clk(d_clk), .rst(rst), .d(req_tgl), .q(req_d));
    eecfg_sync u_ack (.clk(s_clk), .rst(rst), .d(seen_tgl), .q(ack_s));

    // One word in flight; the hold register is stable while the toggle travels
    assign x.s_ready = (req_tgl == ack_s);

    always_ff @(posedge s_clk or posedge rst)
    begin
        if (rst)
        begin
            req_tgl <= 1'h0;
            hold <= '0;
        end
        else if (x.s_valid && x.s_ready)
        begin
            req_tgl <= ~req_tgl;
            hold <= x.s_data;
        end
    end

    always_ff @(posedge d_clk or posedge rst)
    begin
        if (rst)
        begin
            seen_tgl <= 1'h0;
            x.d_valid <= 1'h0;
            x.d_data <= '0;
        end
        else
        begin
            x.d_valid <= (req_d != seen_tgl);
            if (req_d != seen_tgl)
            begin
                seen_tgl <= req_d;
                x.d_data <= hold;
            end
        end
    end
endmodule

// file: rtl/eecfg_top.sv
// Notes on behaviour
// - In enhanced mode, zone bit n guards 8,192-byte zone n, zone 0 lowest.
// - A set zone bit blocks array writes there; each bit written independently.
// - All zone bits reset to zero.
// - In legacy mode the zone bits are ignored for array write permission.
// - Any payload other than exactly three bytes aborts, register unchanged.
// - Confirmation is 99h for new lock one, 66h for new lock zero.
// - Confirmation mismatching the new lock value aborts without change.
// - Register writes and locking ignore the write-protect pin.
// - Once locked, writes are acknowledged, nothing stored, no busy time.
// - A set lock is never cleared again.
// - Continued read acknowledges wrap from the second byte to the first.
// - Device address uses type 1011b, three strap bits, then read/write.
// - Word address needs A15 and A11 one, A10 zero; rest ignored.
// - Mode bit one: pin ignored, zones rule; zero: pin guards whole array.
// - Correction flag shows whether the last array read needed correction.
`timescale 1ns/100ps
module eecfg_top
    import eecfg_pkg::*;
#(
    parameter logic [23:0] WR_CYCLES_P = 24'(WR_CYCLES)
)
(
    // Clocks and reset
    input wire logic mclk,
    input wire logic link_clk,
    input wire logic sys_rst,
    // Two-wire bus pins
    input wire logic scl,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe,
    // Straps and write-protect pin
    input wire logic [2:0] addr_strap,
    input wire logic wp_pin,
    // Nonvolatile copy of the register
    input wire logic [7:0] nv_zone,
    input wire logic nv_mode,
    input wire logic nv_lock,
    output logic nv_store,
    // Array side
    input wire logic [15:0] arr_addr,
    output logic arr_wr_allow,
    input wire logic rd_done,
    input wire logic rd_ecc_used,
    // Register view
    output logic [7:0] zone_protect_bits,
    output logic protection_mode_select,
    output logic cfg_lock,
    output logic correction_used_flag,
    output logic cfg_busy
);
    function automatic logic [2:0] zone_of(input logic [15:0] a);
        return a[15:ZONE_LSB];
    endfunction

    eecfg_xfer_if #(.W(REQ_W)) req_if ();
    eecfg_xfer_if #(.W(SNAP_W)) snap_if ();

    eecfg_xfer u_req (.s_clk(link_clk), .d_clk(mclk), .rst(sys_rst), .x(req_if.xfer));
    eecfg_xfer u_snap (.s_clk(mclk), .d_clk(link_clk), .rst(sys_rst), .x(snap_if.xfer));

    // ---------------- Core domain ----------------
    logic wp_s;
    logic loaded;
    logic [23:0] tmr;
    logic [7:0] pend_zone;
    logic pend_mode;
    logic pend_lock;
    logic [15:0] snap_sent;
    logic [23:0] busy_len;

    eecfg_sync u_wp (.clk(mclk), .rst(sys_rst), .d(wp_pin), .q(wp_s));

    wire [7:0] rq_hi = req_if.d_data[23:16];
    wire [7:0] rq_zone = req_if.d_data[15:8];
    wire [7:0] rq_conf = req_if.d_data[7:0];
    wire [7:0] conf_need = rq_hi[HI_LOCK] ? CONF_LOCK : CONF_OPEN;
    // The write-protect pin plays no part in accepting a register write
    wire wr_accept = req_if.d_valid && loaded && !cfg_lock && !cfg_busy
                     && (rq_conf == conf_need);
    wire [15:0] snap = {correction_used_flag, 5'h00, protection_mode_select, cfg_lock,
                        zone_protect_bits};

    always_ff @(posedge mclk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            zone_protect_bits <= ZONE_RST;
            protection_mode_select <= MODE_RST;
            cfg_lock <= LOCK_RST;
            loaded <= 1'h0;
            cfg_busy <= 1'h0;
            tmr <= 24'h000000;
            pend_zone <= ZONE_RST;
            pend_mode <= MODE_RST;
            pend_lock <= LOCK_RST;
            nv_store <= 1'h0;
        end
        else
        begin
            nv_store <= 1'h0;
            if (!loaded)
            begin
                // Stored contents are taken once, the cycle after reset release
                loaded <= 1'h1;
                zone_protect_bits <= nv_zone;
                protection_mode_select <= nv_mode;
                cfg_lock <= nv_lock;
            end
            else if (wr_accept)
            begin
                pend_zone <= rq_zone;
                pend_mode <= rq_hi[HI_MODE];
                pend_lock <= rq_hi[HI_LOCK];
                cfg_busy <= 1'h1;
                tmr <= WR_CYCLES_P - 24'h000001;
            end
            else if (cfg_busy)
            begin
                if (tmr == 24'h000000)
                begin
                    cfg_busy <= 1'h0;
                    zone_protect_bits <= pend_zone;
                    protection_mode_select <= pend_mode;
                    cfg_lock <= cfg_lock | pend_lock;
                    nv_store <= 1'h1;
                end
                else
                begin
                    tmr <= tmr - 24'h000001;
                end
            end
        end
    end

    always_ff @(posedge mclk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            correction_used_flag <= 1'h0;
        end
        else if (rd_done)
        begin
            correction_used_flag <= rd_ecc_used;
        end
    end

    always_ff @(posedge mclk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            arr_wr_allow <= 1'h0;
        end
        else if (protection_mode_select)
        begin
            arr_wr_allow <= !zone_protect_bits[zone_of(arr_addr)];
        end
        else
        begin
            arr_wr_allow <= !wp_s;
        end
    end

    // The link keeps its own copy; it is refreshed whenever a field changes
    assign snap_if.s_valid = (snap != snap_sent);
    assign snap_if.s_data = snap;

    always_ff @(posedge mclk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            snap_sent <= 16'h0000;
            busy_len <= 24'h000000;
        end
        else
        begin
            if (snap_if.s_valid && snap_if.s_ready)
            begin
                snap_sent <= snap;
            end
            busy_len <= cfg_busy ? busy_len + 24'h000001 : 24'h000000;
        end
    end

    a_lock_sticky: assert property (@(posedge mclk) disable iff (sys_rst)
        cfg_lock |=> cfg_lock)
        else $error("lock bit cleared");
    a_zone_block: assert property (@(posedge mclk) disable iff (sys_rst)
        (protection_mode_select && zone_protect_bits[zone_of(arr_addr)] && loaded)
        |=> !arr_wr_allow)
        else $error("write allowed into protected zone");
    a_legacy_pin: assert property (@(posedge mclk) disable iff (sys_rst)
        (!protection_mode_select && loaded) |=> (arr_wr_allow == !$past(wp_s)))
        else $error("legacy permission does not follow pin");
    a_bad_confirm: assert property (@(posedge mclk) disable iff (sys_rst)
        (req_if.d_valid && !cfg_busy && rq_conf != conf_need)
        |=> (!cfg_busy && $stable(zone_protect_bits)))
        else $error("mismatched confirmation started a write");
    a_locked_ignore: assert property (@(posedge mclk) disable iff (sys_rst)
        (req_if.d_valid && cfg_lock && loaded) |=> !cfg_busy ##1 !cfg_busy)
        else $error("locked register started a write cycle");
    a_lock_confirm: assert property (@(posedge mclk) disable iff (sys_rst)
        (req_if.d_valid && loaded && !cfg_lock && !cfg_busy && rq_hi[HI_LOCK]
         && rq_conf == CONF_LOCK) |=> cfg_busy && pend_lock)
        else $error("valid lock request not accepted");
    a_cycle_len: assert property (@(posedge mclk) disable iff (sys_rst)
        $fell(cfg_busy) |-> (busy_len == WR_CYCLES_P))
        else $error("write cycle length wrong");
    a_ecs_track: assert property (@(posedge mclk) disable iff (sys_rst)
        rd_done |=> (correction_used_flag == $past(rd_ecc_used)))
        else $error("correction flag not updated");

    // ---------------- Link domain ----------------
    logic scl_s;
    logic sda_s;
    logic scl_p;
    logic sda_p;
    logic [2:0] strap_s;
    logic busy_l;
    eecfg_lst_t st;
    eecfg_lst_t nxt;
    eecfg_lst_t next_st;
    logic [3:0] bit_cnt;
    logic [7:0] sh;
    logic sda_drv;
    logic host_ack;
    logic rd_idx;
    logic addr_ok;
    logic foreign;
    logic [2:0] wcnt;
    logic [7:0] wb0;
    logic [7:0] wb1;
    logic [7:0] wb2;
    logic [15:0] cfg_copy;

    eecfg_sync #(.W(2)) u_pins (.clk(link_clk), .rst(sys_rst), .d({scl, sda_in}),
                               .q({scl_s, sda_s}));
    eecfg_sync #(.W(3)) u_strap (.clk(link_clk), .rst(sys_rst), .d(addr_strap), .q(strap_s));
    eecfg_sync u_busy (.clk(link_clk), .rst(sys_rst), .d(cfg_busy), .q(busy_l));

    wire scl_rise = scl_s && !scl_p;
    wire scl_fall = !scl_s && scl_p;
    wire bus_start = scl_s && scl_p && sda_p && !sda_s;
    wire bus_stop = scl_s && scl_p && !sda_p && sda_s;
    wire type_ok = (sh[7:4] == DEV_TYPE) && (sh[3:1] == strap_s);
    wire other_cmd = (sh[7:4] != DEV_TYPE) && (sh[3:1] == strap_s);
    // Reads need an address from this frame; writes need a clean bus
    wire dev_ack = type_ok && !busy_l && (sh[0] ? addr_ok : !foreign);
    wire ahi_ok = sh[WA_A15] && sh[WA_A11] && !sh[WA_A10];
    wire rx_ack = (st == ST_DEV) ? dev_ack : (st == ST_AHI) ? ahi_ok : 1'h1;
    wire [7:0] tx_byte = rd_idx ? cfg_copy[7:0] : cfg_copy[15:8];

    always_comb
    begin
        unique case (st)
            ST_DEV: next_st = dev_ack ? (sh[0] ? ST_RDAT : ST_AHI) : ST_IDLE;
            ST_AHI: next_st = ahi_ok ? ST_ALO : ST_IDLE;
            ST_ALO: next_st = ST_WDAT;
            ST_WDAT: next_st = ST_WDAT;
            ST_RDAT: next_st = ST_RDAT;
            default: next_st = ST_IDLE;
        endcase
    end

    // Only an exact three-byte payload closed by Stop becomes a request
    assign req_if.s_valid = bus_stop && (st == ST_WDAT) && (wcnt == WCNT_FULL);
    assign req_if.s_data = {wb0, wb1, wb2};
    assign sda_out = 1'h0;
    assign sda_oe = sda_drv;

    always_ff @(posedge link_clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            // Same level as the synchroniser reset, so release shows no false edge
            scl_p <= 1'h0;
            sda_p <= 1'h0;
            cfg_copy <= 16'h0000;
        end
        else
        begin
            scl_p <= scl_s;
            sda_p <= sda_s;
            if (snap_if.d_valid)
            begin
                cfg_copy <= snap_if.d_data;
            end
        end
    end

    always_ff @(posedge link_clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            st <= ST_IDLE;
            nxt <= ST_IDLE;
            bit_cnt <= 4'h0;
            sh <= 8'h00;
            sda_drv <= 1'h0;
            host_ack <= 1'h0;
            rd_idx <= 1'h0;
            addr_ok <= 1'h0;
            foreign <= 1'h0;
            wcnt <= 3'h0;
            wb0 <= 8'h00;
            wb1 <= 8'h00;
            wb2 <= 8'h00;
        end
        else if (bus_start || bus_stop)
        begin
            st <= bus_start ? ST_DEV : ST_IDLE;
            bit_cnt <= 4'h0;
            sda_drv <= 1'h0;
            wcnt <= 3'h0;
            if (bus_stop)
            begin
                addr_ok <= 1'h0;
                foreign <= 1'h0;
            end
        end
        else if (scl_rise && st != ST_IDLE)
        begin
            if (bit_cnt < BIT_ACK)
            begin
                bit_cnt <= bit_cnt + 4'h1;
                sh <= {sh[6:0], sda_s};
            end
            else if (bit_cnt == BIT_ACK_END)
            begin
                host_ack <= !sda_s;
            end
        end
        else if (scl_fall && st == ST_RDAT)
        begin
            if (bit_cnt == BIT_ACK)
            begin
                sda_drv <= 1'h0;
                bit_cnt <= BIT_ACK_END;
            end
            else if (bit_cnt == BIT_ACK_END)
            begin
                bit_cnt <= 4'h0;
                sh <= tx_byte;
                sda_drv <= host_ack && !tx_byte[7];
                rd_idx <= !rd_idx;
                st <= host_ack ? ST_RDAT : ST_IDLE;
            end
            else if (bit_cnt != 4'h0)
            begin
                sda_drv <= !sh[7];
            end
        end
        else if (scl_fall && st != ST_IDLE)
        begin
            if (bit_cnt == BIT_ACK)
            begin
                sda_drv <= rx_ack;
                nxt <= next_st;
                bit_cnt <= BIT_ACK_END;
                if (st == ST_DEV && other_cmd)
                begin
                    foreign <= 1'h1;
                end
                if (st == ST_ALO)
                begin
                    addr_ok <= 1'h1;
                end
                if (st == ST_WDAT)
                begin
                    wb0 <= (wcnt == 3'h0) ? sh : wb0;
                    wb1 <= (wcnt == 3'h1) ? sh : wb1;
                    wb2 <= (wcnt == 3'h2) ? sh : wb2;
                    wcnt <= (wcnt == WCNT_OVER) ? wcnt : wcnt + 3'h1;
                end
            end
            else if (bit_cnt == BIT_ACK_END)
            begin
                bit_cnt <= 4'h0;
                st <= nxt;
                sda_drv <= (nxt == ST_RDAT) && !cfg_copy[15];
                if (nxt == ST_RDAT)
                begin
                    sh <= cfg_copy[15:8];
                    rd_idx <= 1'h1;
                end
            end
        end
    end

    a_dev_nack: assert property (@(posedge link_clk) disable iff (sys_rst)
        (st == ST_DEV && scl_fall && bit_cnt == BIT_ACK && !type_ok) |=> !sda_drv)
        else $error("foreign device address acknowledged");
    a_addr_check: assert property (@(posedge link_clk) disable iff (sys_rst)
        (st == ST_AHI && scl_fall && bit_cnt == BIT_ACK && !bus_start && !bus_stop)
        |=> (sda_drv == $past(ahi_ok)))
        else $error("word address check wrong");
    a_rd_wrap: assert property (@(posedge link_clk) disable iff (sys_rst)
        (st == ST_RDAT && scl_fall && bit_cnt == BIT_ACK_END && host_ack
         && !bus_start && !bus_stop) |=> (rd_idx != $past(rd_idx)) && st == ST_RDAT)
        else $error("read did not wrap");
endmodule

// file: testbench/eecfg_host.sv
`timescale 1ns/100ps
module eecfg_host
(
    // Bus pins
    output logic scl,
    input wire logic sda_oe,
    output logic sda_wire
);
    logic hlow = 1'b0;
    initial scl = 1'b1;
    // Pull-up wins whenever neither party pulls low
    assign sda_wire = ~(hlow | sda_oe);
    // Also serves as repeated Start; scl stays still between frames
    task automatic start();
        hlow = 1'b0;
        #30 scl = 1'b1;
        #40 hlow = 1'b1;
        #40 scl = 1'b0;
    endtask
    task automatic stop();
        #30 hlow = 1'b1;
        #30 scl = 1'b1;
        #40 hlow = 1'b0;
        #40;
    endtask
    task automatic wbyte(input logic [7:0] b, output logic ack);
        for (int i = 7; i >= 0; i--)
        begin
            #30 hlow = ~b[i];
            #30 scl = 1'b1;
            #40 scl = 1'b0;
        end
        #30 hlow = 1'b0;
        #30 scl = 1'b1;
        ack = ~sda_wire;
        #40 scl = 1'b0;
    endtask
    // Host acknowledge low keeps the read going; high ends it
    task automatic rbyte(input logic nack, output logic [7:0] b);
        #10 hlow = 1'b0;
        for (int i = 7; i >= 0; i--)
        begin
            #50 scl = 1'b1;
            b[i] = sda_wire;
            #40 scl = 1'b0;
            #10;
        end
        #20 hlow = ~nack;
        #30 scl = 1'b1;
        #40 scl = 1'b0;
    endtask
endmodule

// file: testbench/test_eeprom_config_register_protection.sv
`timescale 1ns/100ps
module test_eeprom_config_register_protection;
    import eecfg_pkg::*;
    localparam logic [2:0] STRAP = 3'h5;
    localparam logic [7:0] DW = {4'hb, STRAP, 1'b0};
    logic mclk = 1'b0;
    logic link_clk = 1'b0;
    logic sys_rst = 1'b1;
    logic scl, sda_in, sda_out, sda_oe, wp_pin, nv_store, arr_wr_allow, rd_done, rd_ecc_used;
    logic [15:0] arr_addr = 16'h0000;
    logic [7:0] zone_protect_bits;
    logic protection_mode_select, cfg_lock, correction_used_flag, cfg_busy;
    int n_fail = 0;
    int total_checks = 0;
    always #2 mclk = ~mclk;
    always #3 link_clk = ~link_clk;
    initial
    begin
        wp_pin = 1'b0;
        rd_done = 1'b0;
        rd_ecc_used = 1'b0;
    end
    eecfg_top #(.WR_CYCLES_P(24'h14)) eecfg_top_i (
        .mclk(mclk), .link_clk(link_clk), .sys_rst(sys_rst),
        .scl(scl), .sda_in(sda_in), .sda_out(sda_out), .sda_oe(sda_oe),
        .addr_strap(STRAP), .wp_pin(wp_pin),
        .nv_zone(8'h00), .nv_mode(1'b0), .nv_lock(1'b0), .nv_store(nv_store),
        .arr_addr(arr_addr), .arr_wr_allow(arr_wr_allow),
        .rd_done(rd_done), .rd_ecc_used(rd_ecc_used),
        .zone_protect_bits(zone_protect_bits), .protection_mode_select(protection_mode_select),
        .cfg_lock(cfg_lock), .correction_used_flag(correction_used_flag), .cfg_busy(cfg_busy)
    );
    eecfg_host eecfg_host_i (.scl(scl), .sda_oe(sda_oe), .sda_wire(sda_in));
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        total_checks++;
        if (seen !== exp)
        begin
            n_fail++;
            $display("CHECK FAILED at %0t: saw %h, expected %h", $time, seen, exp);
        end
    endtask
    task automatic close_out();
        $display("Checks made %0d, mismatches %0d", total_checks, n_fail);
        if (n_fail == 0 && total_checks > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    // Device, address, then n of {upper byte, zone byte, confirmation}
    task automatic cfg_write(input logic [7:0] hi, zn, cf, input int n, input logic exp_busy);
        logic a;
        logic b;
        logic s;
        b = 1'b0;
        s = 1'b0;
        eecfg_host_i.start();
        eecfg_host_i.wbyte(DW, a);
        check(a, 1'b1);
        eecfg_host_i.wbyte(8'h88, a);
        eecfg_host_i.wbyte(8'h00, a);
        if (n > 0)
            eecfg_host_i.wbyte(hi, a);
        if (n > 1)
            eecfg_host_i.wbyte(zn, a);
        if (n > 2)
            eecfg_host_i.wbyte(cf, a);
        check(a, 1'b1);
        eecfg_host_i.stop();
        // Window spans the crossing, the whole timed cycle and the commit pulse
        repeat (100)
        begin
            @(negedge mclk);
            b = b | (cfg_busy === 1'b1);
            s = s | (nv_store === 1'b1);
        end
        check(b, exp_busy);
        check(s, exp_busy);
        check(cfg_busy, 1'b0);
    endtask
    // Random read with repeated Start, three bytes to see the wrap
    task automatic read_chk(input logic [7:0] hi, zn);
        logic a;
        logic [7:0] r0, r1, r2;
        eecfg_host_i.start();
        eecfg_host_i.wbyte(DW, a);
        eecfg_host_i.wbyte(8'h88, a);
        eecfg_host_i.wbyte(8'h00, a);
        eecfg_host_i.start();
        eecfg_host_i.wbyte(DW | 8'h01, a);
        check(a, 1'b1);
        eecfg_host_i.rbyte(1'b0, r0);
        eecfg_host_i.rbyte(1'b0, r1);
        eecfg_host_i.rbyte(1'b1, r2);
        eecfg_host_i.stop();
        check(r0, hi);
        check(r1, zn);
        check(r2, hi);
        check(zone_protect_bits, zn);
        check(protection_mode_select, hi[HI_MODE]);
        check(cfg_lock, hi[HI_LOCK]);
    endtask
    task automatic allow_chk(input logic [15:0] ad, input logic exp);
        @(negedge mclk);
        arr_addr = ad;
        repeat (4) @(posedge mclk);
        #1 check(arr_wr_allow, exp);
    endtask
    initial
    begin
        logic a;
        repeat (12) @(negedge mclk);
        sys_rst = 1'b0;
        repeat (20) @(negedge mclk);
        check(zone_protect_bits, ZONE_RST);
        read_chk(8'h00, 8'h00);
        $display("Test reset values done");
        @(negedge mclk) wp_pin = 1'b1;
        cfg_write(8'h02, 8'ha5, CONF_OPEN, 3, 1'b1);
        read_chk(8'h02, 8'ha5);
        // Top byte of each zone, zone 0 lowest
        for (int z = 0; z < 8; z++)
            allow_chk(16'(z * ZONE_BYTES + ZONE_BYTES - 1), ~8'ha5 >> z);
        $display("Test zone protection done");
        cfg_write(8'h03, 8'h00, CONF_OPEN, 3, 1'b0);
        cfg_write(8'h02, 8'h00, CONF_LOCK, 3, 1'b0);
        cfg_write(8'h00, 8'h00, CONF_OPEN, 2, 1'b0);
        cfg_write(8'h00, 8'h00, 8'h00, 1, 1'b0);
        read_chk(8'h02, 8'ha5);
        $display("Test aborted writes done");
        cfg_write(8'h00, 8'hff, CONF_OPEN, 3, 1'b1);
        allow_chk(16'h0000, 1'b0);
        @(negedge mclk) wp_pin = 1'b0;
        allow_chk(16'hffff, 1'b1);
        $display("Test legacy mode done");
        @(negedge mclk);
        rd_done = 1'b1;
        rd_ecc_used = 1'b1;
        @(negedge mclk);
        rd_done = 1'b0;
        rd_ecc_used = 1'b0;
        check(correction_used_flag, 1'b1);
        read_chk(8'h80, 8'hff);
        $display("Test correction flag done");
        @(negedge mclk) wp_pin = 1'b1;
        cfg_write(8'h03, 8'h0f, CONF_LOCK, 3, 1'b1);
        read_chk(8'h83, 8'h0f);
        cfg_write(8'h02, 8'h00, CONF_OPEN, 3, 1'b0);
        read_chk(8'h83, 8'h0f);
        $display("Test lock done");
        eecfg_host_i.start();
        eecfg_host_i.wbyte({4'hb, ~STRAP, 1'b0}, a);
        check(a, 1'b0);
        eecfg_host_i.stop();
        eecfg_host_i.start();
        eecfg_host_i.wbyte({4'ha, STRAP, 1'b0}, a);
        check(a, 1'b0);
        eecfg_host_i.stop();
        eecfg_host_i.start();
        eecfg_host_i.wbyte(DW, a);
        eecfg_host_i.wbyte(8'h8c, a);
        check(a, 1'b0);
        eecfg_host_i.stop();
        check(sda_out, 1'b0);
        $display("Test address refusal done");
        // Foreign-type command left open by a repeated Start blocks register writes
        eecfg_host_i.start();
        eecfg_host_i.wbyte({4'ha, STRAP, 1'b0}, a);
        eecfg_host_i.start();
        eecfg_host_i.wbyte(DW, a);
        check(a, 1'b0);
        eecfg_host_i.stop();
        // A Stop after the word address leaves nothing to read from
        eecfg_host_i.start();
        eecfg_host_i.wbyte(DW, a);
        eecfg_host_i.wbyte(8'h88, a);
        eecfg_host_i.wbyte(8'h00, a);
        eecfg_host_i.stop();
        eecfg_host_i.start();
        eecfg_host_i.wbyte(DW | 8'h01, a);
        check(a, 1'b0);
        eecfg_host_i.stop();
        $display("Test open command refusal done");
        close_out();
    end
    // Whole sequence needs roughly 90 us of bus traffic
    initial
    begin
        #300000;
        n_fail++;
        close_out();
    end
endmodule
